// ### core/tpc_pkg.sv
// Constants and types shared by the test port command executor
package tpc_pkg;

  localparam int FLD_W = 16;
  localparam int STAT_W = 7;

  // Own select address; value is arbitrary
  localparam logic [7:0] OWN_ADDR = 8'h5A;

  // Header field layout
  localparam int HDR_ADDR_MSB = 15;
  localparam int HDR_ADDR_LSB = 8;
  localparam int HDR_CMD_MSB = 7;
  localparam int HDR_CMD_LSB = 0;

  // Command codes
  localparam logic [7:0] CMD_CONN_BP = 8'h01;
  localparam logic [7:0] CMD_DISC_BP = 8'h02;
  localparam logic [7:0] CMD_CONN_RES = 8'h03;
  localparam logic [7:0] CMD_DISC_RES = 8'h04;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CMD_READ = 8'h06;
  localparam logic [7:0] CMD_RD_STATUS = 8'h07;

  // Field check code
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // Status bit positions
  localparam int ST_CMD_ERR = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_BP_CONN = 3;
  localparam int ST_RES_CONN = 4;
  localparam int ST_IDLE = 5;
  localparam int ST_RESET = 6;
  localparam logic [STAT_W-1:0] STATUS_RESET = 7'h00;

  // Executor states
  typedef enum logic [3:0] {
    S_HDR, S_SADDR, S_CNT, S_DATA, S_MEMWR, S_CRC,
    S_ACKHDR, S_RDMEM, S_ACKDATA, S_ACKCRC, S_ACKEND
  } tpc_state_t;

endpackage

// ### core/tpc_executor.sv
// Command executor of the commandable test port, with its link-clock front end
`timescale 1ns/1ps
module tpc_executor
  import tpc_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  input  wire logic              LCLK_I,
  input  wire logic [FLD_W-1:0]  SEL_FIELD_I,
  input  wire logic              SEL_VALID_I,
  input  wire logic              SEL_FIRST_I,
  output logic                   SEL_READY_O,
  output logic [FLD_W-1:0]       ACK_FIELD_O,
  output logic                   ACK_VALID_O,
  output logic                   ACK_LAST_O,
  output logic [FLD_W-1:0]       MEMORY_IO_PORT_ADDR_O,
  output logic [FLD_W-1:0]       MEMORY_IO_PORT_WDATA_O,
  output logic                   MEMORY_IO_PORT_WR_O,
  output logic                   MEMORY_IO_PORT_RD_O,
  input  wire logic [FLD_W-1:0]  MEMORY_IO_PORT_RDATA_I,
  input  wire logic              MEMORY_IO_PORT_DONE_I,
  input  wire logic              INTERRUPT_PORT_I,
  input  wire logic              BACKPLANE_PORT_TCK_I,
  input  wire logic              BACKPLANE_PORT_TMS_I,
  input  wire logic              BACKPLANE_PORT_TDI_I,
  output logic                   BACKPLANE_PORT_TDO_O,
  input  wire logic              RESIDENT_PORT_TCK_I,
  input  wire logic              RESIDENT_PORT_TMS_I,
  input  wire logic              RESIDENT_PORT_TDI_I,
  output logic                   RESIDENT_PORT_TDO_O,
  output logic                   BOARD_SIDE_PORT_TCK_O,
  output logic                   BOARD_SIDE_MODE_SELECT_O,
  output logic                   BOARD_SIDE_PORT_TDI_O,
  input  wire logic              BOARD_SIDE_PORT_TDO_I,
  output logic [STAT_W-1:0]      PORT_STATUS_O
);

  typedef struct packed {
    logic [FLD_W-1:0] fld;
    logic             first;
    logic             req_tgl;
    logic [1:0]       rxack_sync;
    logic [1:0]       tx_sync;
    logic             tx_seen;
    logic [FLD_W-1:0] ack_word;
    logic             ack_valid;
    logic             ack_last;
  } tpc_link_t;

  typedef struct packed {
    tpc_state_t       state;
    logic [1:0]       req_sync;
    logic             rx_ack;
    logic [1:0]       done_sync;
    logic             tx_tgl;
    logic [FLD_W-1:0] tx_word;
    logic             tx_last;
    logic [FLD_W-1:0] tx_crc;
    logic [FLD_W-1:0] rx_crc;
    logic [7:0]       cmd;
    logic             ack_long;
    logic [FLD_W-1:0] mem_addr;
    logic [FLD_W-1:0] mem_wdata;
    logic             mem_wr;
    logic             mem_rd;
    logic [FLD_W-1:0] rd_hold;
    logic [FLD_W-1:0] count;
    logic [1:0]       int_sync;
    logic [1:0]       tms_sync;
    logic             err_cmd;
    logic             err_crc;
    logic             irq;
    logic             bp_conn;
    logic             res_conn;
    logic             route_bp;
    logic             route_res;
  } tpc_core_t;

  tpc_link_t         link_reg;
  tpc_link_t         link_next;
  tpc_core_t         core_reg;
  tpc_core_t         core_next;
  logic              fld_pend;
  logic              tx_idle;
  logic [STAT_W-1:0] status_vec;
  logic              tms_out;

  function automatic logic [FLD_W-1:0] crc_step(input logic [FLD_W-1:0] crc, input logic [FLD_W-1:0] data);
    logic [FLD_W-1:0] c;
    logic             fb;
    c = crc;
    for (int i = FLD_W - 1; i >= 0; i--)
    begin
      fb = c[FLD_W-1] ^ data[i];
      c = {c[FLD_W-2:0], 1'b0};
      if (fb)
      begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  // Link side: field capture and acknowledge output
  always_comb
  begin
    link_next = link_reg;
    link_next.rxack_sync = {link_reg.rxack_sync[0], core_reg.rx_ack};
    link_next.tx_sync = {link_reg.tx_sync[0], core_reg.tx_tgl};
    link_next.ack_valid = 1'b0;
    if (SEL_VALID_I && SEL_READY_O)
    begin
      link_next.fld = SEL_FIELD_I;
      link_next.first = SEL_FIRST_I;
      link_next.req_tgl = ~link_reg.req_tgl;
    end
    if (link_reg.tx_sync[1] != link_reg.tx_seen)
    begin
      link_next.ack_word = core_reg.tx_word;
      link_next.ack_last = core_reg.tx_last;
      link_next.ack_valid = 1'b1;
      link_next.tx_seen = link_reg.tx_sync[1];
    end
  end

  always_ff @(posedge LCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      link_reg <= '0;
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  assign SEL_READY_O = (link_reg.req_tgl == link_reg.rxack_sync[1]);
  assign ACK_FIELD_O = link_reg.ack_word;
  assign ACK_VALID_O = link_reg.ack_valid;
  assign ACK_LAST_O = link_reg.ack_last;

  assign tms_out = core_reg.route_bp ? BACKPLANE_PORT_TMS_I : (core_reg.route_res ? RESIDENT_PORT_TMS_I : 1'b0);
  assign BOARD_SIDE_MODE_SELECT_O = tms_out;
  assign BOARD_SIDE_PORT_TCK_O = core_reg.route_bp ? BACKPLANE_PORT_TCK_I
                               : (core_reg.route_res ? RESIDENT_PORT_TCK_I : 1'b0);
  assign BOARD_SIDE_PORT_TDI_O = core_reg.route_bp ? BACKPLANE_PORT_TDI_I
                               : (core_reg.route_res ? RESIDENT_PORT_TDI_I : 1'b0);
  assign BACKPLANE_PORT_TDO_O = core_reg.route_bp & BOARD_SIDE_PORT_TDO_I;
  assign RESIDENT_PORT_TDO_O = core_reg.route_res & ~core_reg.route_bp & BOARD_SIDE_PORT_TDO_I;

  always_comb
  begin
    status_vec = STATUS_RESET;
    status_vec[ST_CMD_ERR] = core_reg.err_cmd;
    status_vec[ST_CRC_ERR] = core_reg.err_crc;
    status_vec[ST_IRQ] = core_reg.irq;
    status_vec[ST_BP_CONN] = core_reg.bp_conn;
    status_vec[ST_RES_CONN] = core_reg.res_conn;
    status_vec[ST_IDLE] = ~core_reg.tms_sync[1];
    status_vec[ST_RESET] = core_reg.tms_sync[1];
  end

  assign PORT_STATUS_O = status_vec;
  assign fld_pend = (core_reg.req_sync[1] != core_reg.rx_ack);
  assign tx_idle = (core_reg.done_sync[1] == core_reg.tx_tgl);

  always_comb
  begin
    core_next = core_reg;
    core_next.req_sync = {core_reg.req_sync[0], link_reg.req_tgl};
    core_next.done_sync = {core_reg.done_sync[0], link_reg.tx_seen};
    core_next.int_sync = {core_reg.int_sync[0], INTERRUPT_PORT_I};
    core_next.tms_sync = {core_reg.tms_sync[0], tms_out};
    case (core_reg.state)
      S_HDR:
      begin
        if (fld_pend)
        begin
          core_next.rx_ack = ~core_reg.rx_ack;
          if (link_reg.first && link_reg.fld[HDR_ADDR_MSB:HDR_ADDR_LSB] == OWN_ADDR)
          begin
            core_next.rx_crc = crc_step(CRC_INIT, link_reg.fld);
            core_next.cmd = link_reg.fld[HDR_CMD_MSB:HDR_CMD_LSB];
            core_next.err_cmd = 1'b0;
            core_next.err_crc = 1'b0;
            core_next.ack_long = 1'b0;
            case (link_reg.fld[HDR_CMD_MSB:HDR_CMD_LSB])
              CMD_WRITE, CMD_READ:
              begin
                core_next.state = S_SADDR;
              end
              CMD_CONN_BP, CMD_DISC_BP, CMD_CONN_RES, CMD_DISC_RES, CMD_RD_STATUS:
              begin
                core_next.state = S_CRC;
              end
              default:
              begin
                core_next.err_cmd = 1'b1;
                core_next.state = S_ACKHDR;
              end
            endcase
          end
        end
      end
      S_SADDR:
      begin
        if (fld_pend)
        begin
          core_next.rx_ack = ~core_reg.rx_ack;
          core_next.mem_addr = link_reg.fld;
          core_next.rx_crc = crc_step(core_reg.rx_crc, link_reg.fld);
          core_next.state = S_CNT;
        end
      end
      S_CNT:
      begin
        if (fld_pend)
        begin
          core_next.rx_ack = ~core_reg.rx_ack;
          core_next.count = link_reg.fld;
          core_next.rx_crc = crc_step(core_reg.rx_crc, link_reg.fld);
          core_next.state = (core_reg.cmd == CMD_WRITE && link_reg.fld != '0) ? S_DATA : S_CRC;
        end
      end
      S_DATA:
      begin
        if (fld_pend)
        begin
          core_next.mem_wdata = link_reg.fld;
          core_next.mem_wr = 1'b1;
          core_next.rx_crc = crc_step(core_reg.rx_crc, link_reg.fld);
          core_next.state = S_MEMWR;
        end
      end
      S_MEMWR:
      begin
        if (MEMORY_IO_PORT_DONE_I)
        begin
          core_next.mem_wr = 1'b0;
          // Release the link for the next field only now
          core_next.rx_ack = ~core_reg.rx_ack;
          core_next.count = core_reg.count - 16'h0001;
          if (core_reg.count == 16'h0001)
          begin
            core_next.state = S_CRC;
          end
          else
          begin
            core_next.mem_addr = core_reg.mem_addr + 16'h0001;
            core_next.state = S_DATA;
          end
        end
      end
      S_CRC:
      begin
        if (fld_pend)
        begin
          core_next.rx_ack = ~core_reg.rx_ack;
          core_next.state = S_ACKHDR;
          if (link_reg.fld != core_reg.rx_crc)
          begin
            core_next.err_crc = 1'b1;
          end
          else
          begin
            case (core_reg.cmd)
              CMD_CONN_BP:
              begin
                core_next.bp_conn = 1'b1;
              end
              CMD_DISC_BP:
              begin
                core_next.bp_conn = 1'b0;
              end
              CMD_CONN_RES:
              begin
                core_next.res_conn = 1'b1;
              end
              CMD_DISC_RES:
              begin
                core_next.res_conn = 1'b0;
              end
              CMD_READ:
              begin
                core_next.ack_long = (core_reg.count != '0);
              end
              default:
              begin
                core_next.ack_long = 1'b0;
              end
            endcase
          end
        end
      end
      S_ACKHDR:
      begin
        if (tx_idle)
        begin
          core_next.tx_word = {OWN_ADDR, 1'b0, status_vec};
          core_next.tx_last = 1'b0;
          core_next.tx_tgl = ~core_reg.tx_tgl;
          core_next.tx_crc = crc_step(CRC_INIT, core_next.tx_word);
          core_next.mem_rd = core_reg.ack_long;
          core_next.state = core_reg.ack_long ? S_RDMEM : S_ACKCRC;
        end
      end
      S_RDMEM:
      begin
        if (MEMORY_IO_PORT_DONE_I)
        begin
          core_next.mem_rd = 1'b0;
          core_next.rd_hold = MEMORY_IO_PORT_RDATA_I;
          core_next.count = core_reg.count - 16'h0001;
          core_next.state = S_ACKDATA;
        end
      end
      S_ACKDATA:
      begin
        if (tx_idle)
        begin
          core_next.tx_word = core_reg.rd_hold;
          core_next.tx_tgl = ~core_reg.tx_tgl;
          core_next.tx_crc = crc_step(core_reg.tx_crc, core_reg.rd_hold);
          if (core_reg.count == '0)
          begin
            core_next.state = S_ACKCRC;
          end
          else
          begin
            core_next.mem_addr = core_reg.mem_addr + 16'h0001;
            core_next.mem_rd = 1'b1;
            core_next.state = S_RDMEM;
          end
        end
      end
      S_ACKCRC:
      begin
        if (tx_idle)
        begin
          core_next.tx_word = core_reg.tx_crc;
          core_next.tx_last = 1'b1;
          core_next.tx_tgl = ~core_reg.tx_tgl;
          core_next.state = S_ACKEND;
        end
      end
      S_ACKEND:
      begin
        if (tx_idle)
        begin
          core_next.route_bp = core_reg.bp_conn;
          core_next.route_res = core_reg.res_conn;
          if (core_reg.cmd == CMD_RD_STATUS && !core_reg.err_crc)
          begin
            core_next.irq = 1'b0;
          end
          core_next.state = S_HDR;
        end
      end
      default:
      begin
        core_next.state = S_HDR;
      end
    endcase
    if (core_reg.int_sync[1])
    begin
      core_next.irq = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      core_reg <= '0;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign MEMORY_IO_PORT_ADDR_O = core_reg.mem_addr;
  assign MEMORY_IO_PORT_WDATA_O = core_reg.mem_wdata;
  assign MEMORY_IO_PORT_WR_O = core_reg.mem_wr;
  assign MEMORY_IO_PORT_RD_O = core_reg.mem_rd;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);

  bp_join_order_a: assert property ($rose(core_reg.route_bp) |-> core_reg.bp_conn && $past(core_reg.tx_last))
    else $error("backplane joined without prior acknowledge");
  bp_split_order_a: assert property ($fell(core_reg.route_bp) |-> !core_reg.bp_conn && $past(core_reg.tx_last))
    else $error("backplane separated with bit still set");
  res_join_order_a: assert property ($rose(core_reg.route_res) |-> core_reg.res_conn && $past(core_reg.tx_last))
    else $error("resident joined without bit set");
  res_split_order_a: assert property ($fell(core_reg.route_res) |-> !core_reg.res_conn && $past(core_reg.tx_last))
    else $error("resident separated with bit still set");
  wr_hold_a: assert property (core_reg.mem_wr && !MEMORY_IO_PORT_DONE_I |=> core_reg.mem_wr && $stable(core_reg.mem_wdata))
    else $error("write field dropped before done");
  wr_count_dec_a: assert property (core_reg.state == S_MEMWR && MEMORY_IO_PORT_DONE_I
                                   |=> core_reg.count == $past(core_reg.count) - 16'h0001)
    else $error("write count not decremented");
  foreign_addr_a: assert property (core_reg.state == S_HDR && fld_pend && link_reg.first
                                   && link_reg.fld[HDR_ADDR_MSB:HDR_ADDR_LSB] != OWN_ADDR
                                   |=> core_reg.state == S_HDR && $stable(core_reg.tx_tgl))
    else $error("foreign frame not discarded");
  crc_err_flag_a: assert property (core_reg.state == S_CRC && fld_pend && link_reg.fld != core_reg.rx_crc
                                   |=> core_reg.err_crc && core_reg.state == S_ACKHDR
                                   && $stable(core_reg.bp_conn) && $stable(core_reg.res_conn))
    else $error("mismatch not flagged or command executed");
  rd_start_a: assert property (core_reg.state == S_ACKHDR && tx_idle && core_reg.ack_long
                               |=> core_reg.mem_rd && core_reg.state == S_RDMEM)
    else $error("read did not start after header");
  crc_tail_a: assert property (core_reg.state == S_ACKCRC && tx_idle
                               |=> core_reg.tx_last && core_reg.tx_word == $past(core_reg.tx_crc))
    else $error("trailing check field wrong");

  write_done_c: cover property (core_reg.state == S_MEMWR && MEMORY_IO_PORT_DONE_I && core_reg.count == 16'h0001);
  read_data_c: cover property (core_reg.state == S_ACKDATA && tx_idle && core_reg.count == '0);
  connect_c: cover property ($rose(core_reg.route_bp));
  crc_error_c: cover property ($rose(core_reg.err_crc));

endmodule

// ### sim/tpc_master.sv
// Backplane master model: sends select frames, collects acknowledge fields
`timescale 1ns/1ps
module tpc_master
  import tpc_pkg::*;
(
  input  wire logic             lclk_i,
  input  wire logic             sel_ready_i,
  input  wire logic [FLD_W-1:0] ack_field_i,
  input  wire logic             ack_valid_i,
  input  wire logic             ack_last_i,
  output logic      [FLD_W-1:0] sel_field_o,
  output logic                  sel_valid_o,
  output logic                  sel_first_o
);
  logic [16:0] aq[$];
  initial
  begin
    sel_field_o = 16'h0000;
    sel_valid_o = 1'b0;
    sel_first_o = 1'b0;
  end
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic send(input logic [15:0] f, input logic first);
    int n;
    @(negedge lclk_i);
    sel_field_o = f;
    sel_valid_o = 1'b1;
    sel_first_o = first;
    n = 0;
    while (!sel_ready_i && n < 400)
    begin
      @(negedge lclk_i);
      n++;
    end
    @(negedge lclk_i);
    sel_valid_o = 1'b0;
    sel_first_o = 1'b0;
    sel_field_o = ~f;
  endtask
  // fields in order, check field last
  task automatic frame(input logic [15:0] f[$], input logic [15:0] bad);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (f[i])
    begin
      send(f[i], i == 0);
      c = crc(c, f[i]);
    end
    send(c ^ bad, 1'b0);
  endtask
  always @(posedge lclk_i)
    if (ack_valid_i === 1'b1)
      aq.push_back({ack_last_i, ack_field_i});
endmodule

// ### sim/tb_test_port_command_executor.sv
// Testbench: master model, memory and board stubs around the executor
`timescale 1ns/1ps
module tb_test_port_command_executor
  import tpc_pkg::*;
;
  logic CLK_I = 0, LCLK_I = 0, NRST_I = 0, MEMORY_IO_PORT_DONE_I = 0, INTERRUPT_PORT_I = 0;
  logic BACKPLANE_PORT_TCK_I = 0, BACKPLANE_PORT_TMS_I = 0, BACKPLANE_PORT_TDI_I = 0;
  logic RESIDENT_PORT_TCK_I = 0, RESIDENT_PORT_TMS_I = 0, RESIDENT_PORT_TDI_I = 0, BOARD_SIDE_PORT_TDO_I = 0;
  logic [FLD_W-1:0] SEL_FIELD_I, ACK_FIELD_O, MEMORY_IO_PORT_ADDR_O, MEMORY_IO_PORT_WDATA_O;
  logic [FLD_W-1:0] MEMORY_IO_PORT_RDATA_I = 0;
  logic SEL_VALID_I, SEL_FIRST_I, SEL_READY_O, ACK_VALID_O, ACK_LAST_O, MEMORY_IO_PORT_WR_O, MEMORY_IO_PORT_RD_O;
  logic BACKPLANE_PORT_TDO_O, RESIDENT_PORT_TDO_O, BOARD_SIDE_PORT_TCK_O, BOARD_SIDE_MODE_SELECT_O;
  logic BOARD_SIDE_PORT_TDI_O;
  logic [STAT_W-1:0] PORT_STATUS_O;
  logic [6:0] st;
  logic [15:0] wq[$];
  int fails = 0, n_tests = 0, cyc = 0, mc = 0;
  always #5 CLK_I = ~CLK_I;
  initial
  begin
    #1.3;
    forever
    begin
      LCLK_I = ~LCLK_I;
      #62.5;
    end
  end
  tpc_executor i_dut (.CLK_I, .NRST_I, .LCLK_I, .SEL_FIELD_I, .SEL_VALID_I, .SEL_FIRST_I, .SEL_READY_O,
    .ACK_FIELD_O, .ACK_VALID_O, .ACK_LAST_O, .MEMORY_IO_PORT_ADDR_O, .MEMORY_IO_PORT_WDATA_O,
    .MEMORY_IO_PORT_WR_O, .MEMORY_IO_PORT_RD_O, .MEMORY_IO_PORT_RDATA_I, .MEMORY_IO_PORT_DONE_I,
    .INTERRUPT_PORT_I, .BACKPLANE_PORT_TCK_I, .BACKPLANE_PORT_TMS_I, .BACKPLANE_PORT_TDI_I,
    .BACKPLANE_PORT_TDO_O, .RESIDENT_PORT_TCK_I, .RESIDENT_PORT_TMS_I, .RESIDENT_PORT_TDI_I,
    .RESIDENT_PORT_TDO_O, .BOARD_SIDE_PORT_TCK_O, .BOARD_SIDE_MODE_SELECT_O, .BOARD_SIDE_PORT_TDI_O,
    .BOARD_SIDE_PORT_TDO_I, .PORT_STATUS_O);
  tpc_master i_mst (.lclk_i(LCLK_I), .sel_ready_i(SEL_READY_O), .ack_field_i(ACK_FIELD_O),
    .ack_valid_i(ACK_VALID_O), .ack_last_i(ACK_LAST_O), .sel_field_o(SEL_FIELD_I),
    .sel_valid_o(SEL_VALID_I), .sel_first_o(SEL_FIRST_I));
  // memory answers late, data captured at completion
  always @(negedge CLK_I)
  begin
    MEMORY_IO_PORT_DONE_I <= 1'b0;
    MEMORY_IO_PORT_RDATA_I <= ~MEMORY_IO_PORT_RDATA_I;
    if ((MEMORY_IO_PORT_WR_O | MEMORY_IO_PORT_RD_O) && !MEMORY_IO_PORT_DONE_I)
    begin
      mc = mc + 1;
      if (mc == 3)
      begin
        mc = 0;
        MEMORY_IO_PORT_DONE_I <= 1'b1;
        MEMORY_IO_PORT_RDATA_I <= MEMORY_IO_PORT_ADDR_O ^ 16'h3C3C;
        if (MEMORY_IO_PORT_WR_O)
        begin
          wq.push_back(MEMORY_IO_PORT_ADDR_O);
          wq.push_back(MEMORY_IO_PORT_WDATA_O);
        end
      end
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] h(input logic [7:0] cmd);
    return {OWN_ADDR, cmd};
  endfunction
  // acknowledge: header, data, check with last flag
  task automatic ack(input logic [15:0] d[$]);
    logic [15:0] c;
    logic [16:0] a;
    int n;
    c = CRC_INIT;
    for (int i = 0; i <= d.size(); i++)
    begin
      n = 0;
      while (i_mst.aq.size() == 0 && n < 3000)
      begin
        @(posedge CLK_I);
        n++;
      end
      a = (i_mst.aq.size() > 0) ? i_mst.aq.pop_front() : 17'h00000;
      chk("ack field", a[15:0], (i < d.size()) ? d[i] : c);
      chk("ack last", a[16], i == d.size());
      if (i < d.size())
        c = i_mst.crc(c, d[i]);
    end
  endtask
  // connect backplane, route only after acknowledge
  task automatic t_conn_bp();
    @(negedge CLK_I);
    BACKPLANE_PORT_TCK_I = 1'b1;
    i_mst.frame('{h(CMD_CONN_BP)}, 16'h0000);
    chk("board tck early", BOARD_SIDE_PORT_TCK_O, 1'b0);
    st[ST_BP_CONN] = 1'b1;
    ack('{{OWN_ADDR, 1'b0, st}});
    repeat (20) @(negedge CLK_I);
    chk("board tck routed", BOARD_SIDE_PORT_TCK_O, 1'b1);
    BOARD_SIDE_PORT_TDO_I = 1'b1;
    BACKPLANE_PORT_TMS_I = 1'b1;
    BACKPLANE_PORT_TDI_I = 1'b1;
    repeat (5) @(negedge CLK_I);
    chk("backplane tdo", BACKPLANE_PORT_TDO_O, 1'b1);
    chk("board mode select", BOARD_SIDE_MODE_SELECT_O, 1'b1);
    chk("board tdi", BOARD_SIDE_PORT_TDI_O, 1'b1);
    chk("reset bit", PORT_STATUS_O, 7'h48);
    BACKPLANE_PORT_TMS_I = 1'b0;
  endtask
  task automatic t_write(input logic [15:0] n);
    logic [15:0] f[$];
    f = '{h(CMD_WRITE), 16'h0100, n};
    for (int i = 0; i < n; i++)
      f.push_back(16'(16'hA000 + i));
    wq.delete();
    i_mst.frame(f, 16'h0000);
    ack('{{OWN_ADDR, 1'b0, st}});
    chk("write count", 16'(wq.size()), 16'(2 * n));
    foreach (wq[i])
      chk("write addr data", wq[i], 16'((i % 2) ? 16'hA000 + i / 2 : 16'h0100 + i / 2));
    chk("route kept", BOARD_SIDE_PORT_TCK_O, 1'b1);
  endtask
  task automatic t_read(input logic [15:0] n);
    logic [15:0] e[$];
    i_mst.frame('{h(CMD_READ), 16'h0200, n}, 16'h0000);
    e = '{{OWN_ADDR, 1'b0, st}};
    for (int i = 0; i < n; i++)
      e.push_back(16'((16'h0200 + i) ^ 16'h3C3C));
    ack(e);
  endtask
  task automatic t_bad();
    i_mst.frame('{h(CMD_CONN_RES)}, 16'h0001);
    ack('{{OWN_ADDR, 1'b0, st | 7'h02}});
    i_mst.send(h(8'h3F), 1'b1);
    ack('{{OWN_ADDR, 1'b0, st | 7'h01}});
    i_mst.frame('{{8'hA5, CMD_RD_STATUS}}, 16'h0000);
    repeat (400) @(negedge CLK_I);
    chk("no ack", 16'(i_mst.aq.size()), 16'h0000);
  endtask
  task automatic t_conns();
    logic [7:0] cm[3] = '{CMD_DISC_BP, CMD_CONN_RES, CMD_DISC_RES};
    logic [6:0] sm[3] = '{7'h20, 7'h30, 7'h20};
    for (int i = 0; i < 3; i++)
    begin
      @(negedge CLK_I);
      RESIDENT_PORT_TCK_I = (i == 1);
      RESIDENT_PORT_TDI_I = (i == 1);
      i_mst.frame('{h(cm[i])}, 16'h0000);
      st = sm[i];
      ack('{{OWN_ADDR, 1'b0, st}});
      repeat (20) @(negedge CLK_I);
      chk("board tck", BOARD_SIDE_PORT_TCK_O, i == 1);
      chk("backplane tdo off", BACKPLANE_PORT_TDO_O, 1'b0);
      chk("resident tdo", RESIDENT_PORT_TDO_O, i == 1);
      chk("board tdi", BOARD_SIDE_PORT_TDI_O, i == 1);
    end
  endtask
  task automatic t_irq();
    @(negedge CLK_I);
    INTERRUPT_PORT_I = 1'b1;
    i_mst.frame('{h(CMD_RD_STATUS)}, 16'h0000);
    ack('{{OWN_ADDR, 1'b0, st | 7'h04}});
    @(negedge CLK_I);
    INTERRUPT_PORT_I = 1'b0;
    i_mst.frame('{h(CMD_RD_STATUS)}, 16'h0000);
    ack('{{OWN_ADDR, 1'b0, st | 7'h04}});
    i_mst.frame('{h(CMD_RD_STATUS)}, 16'h0000);
    ack('{{OWN_ADDR, 1'b0, st}});
  endtask
  initial
  begin
    st = 7'h20;
    repeat (6) @(posedge CLK_I);
    @(negedge CLK_I);
    NRST_I = 1'b1;
    repeat (5) @(negedge CLK_I);
    chk("status after reset", PORT_STATUS_O, 7'h20);
    t_conn_bp();
    t_write(2);
    t_write(1);
    t_read(1);
    t_read(3);
    t_bad();
    t_conns();
    t_irq();
    report_and_stop();
  end
endmodule
